/* acc_asserts.sv */
// checker: bus handshake and register-to-output relations
`timescale 1ns/1ps
module acc_asserts #(parameter int N = 4) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [N-1:0] cmp_on_o,
   input wire logic [3*N-1:0] cmp_neg_sel_o,
   input wire logic [2:0] amp_to_cmp_o,
   input wire logic [2:0] cmp_clk_x2_o,
   input wire logic [7:0] pin_buf_off0_o,
   input wire logic [7:0] pin_buf_off1_o
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   // completed write, one edge per transfer
   wire logic wr = psel && penable && pready && pwrite;
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("answer late");
   a_err_refuse: assert property (pready && paddr == 8'h30 |->
      pslverr && prdata == 32'h0) else $error("unmapped not refused");
   a_ctl0_fields: assert property (wr && paddr == 8'h00 |=>
      cmp_on_o[0] == $past(pwdata[7]) &&
      cmp_neg_sel_o[2:0] == $past(pwdata[2:0])) else $error("ctl0 bad");
   a_ctl_separate: assert property (wr && paddr == 8'h0c |=>
      cmp_on_o[3] == $past(pwdata[7]) && $stable(cmp_on_o[2:0]))
      else $error("ctl3 leaks");
   a_dis0_mask: assert property (wr && paddr == 8'h18 |=>
      pin_buf_off0_o == ($past(pwdata[7:0]) & acc_pkg::DIS0_MASK))
      else $error("dis0 bad");
   a_dis1_mask: assert property (wr && paddr == 8'h1c |=>
      pin_buf_off1_o == ($past(pwdata[7:0]) & acc_pkg::DIS1_MASK))
      else $error("dis1 bad");
   a_amp_clock: assert property (cmp_clk_x2_o == amp_to_cmp_o)
      else $error("amp clock bad");
   c_write: cover property (wr);
   c_refuse: cover property (pready && pslverr);
   c_amp: cover property (amp_to_cmp_o != 3'h0);
endmodule // acc_asserts
bind acc_top acc_asserts #(.N(N)) chk_u (.*);

/* acc_cmp_model.sv */
// partner: comparator cores driving raw output levels
`timescale 1ns/1ps
module acc_cmp_model #(parameter int N = 4) (
   input wire logic [N-1:0] on,
   input wire logic [N-1:0] level,
   output logic [N-1:0] out
);
   // a switched-off core holds its output low
   assign out = on & level;
endmodule // acc_cmp_model

/* acc_pkg.sv */
// package: register map, field layout and carriers for comparator control
// Operation
// - bit 7 switches comparator on or off
// - bit 6 gates comparator interrupt request
// - bits 5:4 pick toggle, fall or rise
// - bit 3 picks pll or io clock
// - bits 2:0 pick negative input source
// - each comparator has own control register
// - one shared status register holds levels, flags
// - status bit 1 mirrors comparator 1 output
// - status bit 0 mirrors comparator 0 output
// - amplifier output feeds positive input when set
// - amplified comparator clocked at twice amp clock
// - first disable register blanks analog pin inputs
// - second disable register blanks comparator pin inputs
package acc_pkg;
   localparam int NCMP = 4; // comparators in the bank
   localparam logic [7:0] A_CTL0 = 8'h00; // control regs 0x00..0x0c
   localparam logic [7:0] A_STAT = 8'h10; // levels [3:0], flags [7:4]
   localparam logic [7:0] A_MASK = 8'h14; // irq mask, same layout
   localparam logic [7:0] A_DIS0 = 8'h18; // pin input disable 0
   localparam logic [7:0] A_DIS1 = 8'h1c; // pin input disable 1
   localparam logic [7:0] A_AMP = 8'h20; // amp routing bits [2:0]
   localparam logic [7:0] A_PIN = 8'h24; // gated pin values, dis1:dis0
   localparam int B_ON = 7;
   localparam int B_IE = 6;
   localparam int B_ISH = 5;
   localparam int B_ISL = 4;
   localparam int B_CKS = 3;
   localparam int B_FLG = 4; // flag base in status
   localparam logic [7:0] CTL_RST = 8'h00;
   localparam logic [7:0] DIS0_MASK = 8'h6d; // bits 6,5,3,2,0
   localparam logic [7:0] DIS1_MASK = 8'h26; // bits 5,2,1
   localparam logic [1:0] IS_TOG = 2'h0;
   localparam logic [1:0] IS_FALL = 2'h2;
   localparam logic [1:0] IS_RISE = 2'h3;
   localparam int NAMP = 3; // amplifiers 0..2
   // per-comparator drive towards the analog core
   typedef struct packed {
      logic on;
      logic pll_clk;
      logic [2:0] neg_sel;
      logic amp_pos;
   } acc_core_t;
endpackage

/* acc_top.sv */
// analog comparator bank control with apb register access
`timescale 1ns/1ps
module acc_top #(
   parameter int N = acc_pkg::NCMP
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [N-1:0] cmp_out, // raw comparator outputs, async
   input wire logic [7:0] pin_raw0, // pin values, disable 0 group
   input wire logic [7:0] pin_raw1, // pin values, disable 1 group
   output logic [N-1:0] cmp_on_o,
   output logic [N-1:0] cmp_pll_clk_o, // 1: pll clock, 0: io_clock
   output logic [3*N-1:0] cmp_neg_sel_o,
   output logic [acc_pkg::NAMP-1:0] amp_to_cmp_o,
   output logic [acc_pkg::NAMP-1:0] cmp_clk_x2_o, // double amp clock
   output logic [7:0] pin_buf_off0_o,
   output logic [7:0] pin_buf_off1_o,
   output logic irq
);
   initial begin
      if (N < 1 || N > acc_pkg::NCMP) $error("acc_top: bad N");
   end

   // address compare shared by read mux, register writes and write-one-clear
   function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
      return a == b;
   endfunction

   // state
   logic [7:0] ctl_r [N];
   logic [7:0] ctl_nxt [N];
   logic [N-1:0] flag_r, flag_nxt;
   logic [N-1:0] mask_r, mask_nxt;
   logic [7:0] dis0_r, dis0_nxt, dis1_r, dis1_nxt;
   logic [acc_pkg::NAMP-1:0] amp_r, amp_nxt;
   logic [N-1:0] s1_r, s2_r, s3_r; // sync chain plus edge history
   logic [7:0] p1a_r, p2a_r, p1b_r, p2b_r; // pin synchronisers
   logic [31:0] rd_r, rd_nxt;
   logic rdy_r, rdy_nxt, err_r, err_nxt, irq_r, irq_nxt;
   logic [N-1:0] ev; // selected output event per comparator
   logic wr, acc, known;

   assign acc = psel && penable && !rdy_r; // access phase before pready; one wait state
   // a write lands only at the edge where the master sees pready high
   assign wr = psel && penable && rdy_r && pwrite;

   // event detect per comparator on synchronised level
   for (genvar i = 0; i < N; i++) begin : g_ev
      always_comb begin
         case (ctl_r[i][acc_pkg::B_ISH:acc_pkg::B_ISL])
            acc_pkg::IS_TOG: ev[i] = s2_r[i] ^ s3_r[i];
            acc_pkg::IS_FALL: ev[i] = s3_r[i] & ~s2_r[i];
            acc_pkg::IS_RISE: ev[i] = s2_r[i] & ~s3_r[i];
            default: ev[i] = 1'b0; // reserved code never fires
         endcase
      end
   end

   // register next values and apb answer
   always_comb begin
      logic [7:0] st;
      st = '0;
      for (int i = 0; i < N; i++) begin
         ctl_nxt[i] = ctl_r[i];
         st[i] = s2_r[i];
         st[acc_pkg::B_FLG + i] = flag_r[i];
      end
      mask_nxt = mask_r;
      dis0_nxt = dis0_r;
      dis1_nxt = dis1_r;
      amp_nxt = amp_r;
      known = 1'b0;
      rd_nxt = rd_r;
      for (int i = 0; i < N; i++) begin
         if (hit(paddr, acc_pkg::A_CTL0 + 8'(4 * i))) begin
            known = 1'b1;
            if (wr) ctl_nxt[i] = pwdata[7:0];
            rd_nxt = {24'h0, ctl_r[i]};
         end
      end
      if (hit(paddr, acc_pkg::A_STAT)) begin
         known = 1'b1;
         rd_nxt = {24'h0, st};
      end
      if (hit(paddr, acc_pkg::A_MASK)) begin
         known = 1'b1;
         if (wr) mask_nxt = pwdata[acc_pkg::B_FLG +: N];
         rd_nxt = 32'h0;
         rd_nxt[acc_pkg::B_FLG +: N] = mask_r;
      end
      if (hit(paddr, acc_pkg::A_DIS0)) begin
         known = 1'b1;
         if (wr) dis0_nxt = pwdata[7:0] & acc_pkg::DIS0_MASK;
         rd_nxt = {24'h0, dis0_r};
      end
      if (hit(paddr, acc_pkg::A_DIS1)) begin
         known = 1'b1;
         if (wr) dis1_nxt = pwdata[7:0] & acc_pkg::DIS1_MASK;
         rd_nxt = {24'h0, dis1_r};
      end
      if (hit(paddr, acc_pkg::A_AMP)) begin
         known = 1'b1;
         if (wr) amp_nxt = pwdata[acc_pkg::NAMP-1:0];
         rd_nxt = {29'h0, amp_r};
      end
      if (hit(paddr, acc_pkg::A_PIN)) begin
         known = 1'b1;
         // disabled buffers read zero
         rd_nxt = {16'h0, p2b_r & ~dis1_r, p2a_r & ~dis0_r};
      end
      if (!acc || pwrite || !known) rd_nxt = 32'h0;
      // flags: set wins over write-one-clear
      flag_nxt = flag_r;
      if (wr && hit(paddr, acc_pkg::A_STAT))
         flag_nxt = flag_r & ~pwdata[acc_pkg::B_FLG +: N];
      flag_nxt = flag_nxt | (ev & on_vec());
      rdy_nxt = acc;
      err_nxt = acc && !known;
      // request needs flag, enable bit and mask
      irq_nxt = |(flag_r & ie_vec() & mask_r);
   end

   // gather enable bits as vectors
   function automatic logic [N-1:0] on_vec();
      for (int i = 0; i < N; i++) on_vec[i] = ctl_r[i][acc_pkg::B_ON];
   endfunction
   function automatic logic [N-1:0] ie_vec();
      for (int i = 0; i < N; i++) ie_vec[i] = ctl_r[i][acc_pkg::B_IE];
   endfunction

   // registers; synchronisers keep stage one private to stage two
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < N; i++) ctl_r[i] <= acc_pkg::CTL_RST;
         flag_r <= '0;
         mask_r <= '0;
         dis0_r <= 8'h00;
         dis1_r <= 8'h00;
         amp_r <= '0;
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         p1a_r <= 8'h00;
         p2a_r <= 8'h00;
         p1b_r <= 8'h00;
         p2b_r <= 8'h00;
         rd_r <= 32'h0;
         rdy_r <= 1'b0;
         err_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         for (int i = 0; i < N; i++) ctl_r[i] <= ctl_nxt[i];
         flag_r <= flag_nxt;
         mask_r <= mask_nxt;
         dis0_r <= dis0_nxt;
         dis1_r <= dis1_nxt;
         amp_r <= amp_nxt;
         s1_r <= cmp_out;
         s2_r <= s1_r;
         s3_r <= s2_r;
         p1a_r <= pin_raw0;
         p2a_r <= p1a_r;
         p1b_r <= pin_raw1;
         p2b_r <= p1b_r;
         rd_r <= rd_nxt;
         rdy_r <= rdy_nxt;
         err_r <= err_nxt;
         irq_r <= irq_nxt;
      end
   end

   // core drive straight from registers
   for (genvar i = 0; i < N; i++) begin : g_core
      assign cmp_on_o[i] = ctl_r[i][acc_pkg::B_ON];
      assign cmp_pll_clk_o[i] = ctl_r[i][acc_pkg::B_CKS];
      assign cmp_neg_sel_o[3*i +: 3] = ctl_r[i][2:0];
   end
   assign amp_to_cmp_o = amp_r;
   // core doubles its clock from the amp clock while routed
   assign cmp_clk_x2_o = amp_r;
   assign pin_buf_off0_o = dis0_r;
   assign pin_buf_off1_o = dis1_r;
   assign prdata = rd_r;
   assign pready = rdy_r;
   assign pslverr = err_r;
   assign irq = irq_r;
endmodule // acc_top

/* test_analog_comparator_control.sv */
// testbench: register traffic, comparator events and pin gating
`timescale 1ns/1ps
module test_analog_comparator_control;
   logic ref_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, er;
   logic [7:0] paddr = 0, pin_raw0 = 0, pin_raw1 = 0;
   logic [31:0] pwdata = 0, prdata, rd, v, d0, d1;
   logic pready, pslverr, irq;
   logic [3:0] lvl = 0, on, cmp_on_o, cmp_out, cmp_pll_clk_o;
   logic [11:0] cmp_neg_sel_o;
   logic [2:0] amp_to_cmp_o, cmp_clk_x2_o;
   logic [7:0] pin_buf_off0_o, pin_buf_off1_o;
   int num_errors = 0, checks_done = 0;
   always #20 ref_clk = ~ref_clk;
   acc_top dut_u (.*);
   acc_cmp_model cmp_u (.on(cmp_on_o), .level(lvl), .out(cmp_out));
   task automatic print_verdict;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         num_errors++;
         $display("mismatch %0t got %h want %h", $time, s, e);
      end
   endtask
   // one transfer; entered just after an edge, bounded wait on pready
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1;
      n = 0;
      // look between edges, where the answer is settled
      do begin
         @(negedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         num_errors++;
         print_verdict();
      end
      rd = prdata;
      er = pslverr;
      @(posedge ref_clk);
      psel <= 0;
      penable <= 0;
      @(posedge ref_clk);
   endtask
   // flag expected for a code and an edge direction
   function automatic logic ev(logic [1:0] c, logic up);
      return c == 2'h0 || (c == 2'h3 && up) || (c == 2'h2 && !up);
   endfunction
   initial begin
      void'($urandom(57));
      repeat (6) @(posedge ref_clk);
      reset <= 0;
      @(posedge ref_clk);
      apb(0, 8'h00, 0);
      chk(rd, acc_pkg::CTL_RST); // reset value
      for (int i = 0; i < 4; i++) begin
         v = $urandom & 32'hff;
         on[i] = v[7];
         apb(1, 8'(4 * i), v);
         apb(0, 8'(4 * i), 0);
         chk(rd, v);
         chk({cmp_on_o[i], cmp_pll_clk_o[i]}, {v[7], v[3]});
         chk(cmp_neg_sel_o[3*i+:3], v[2:0]);
      end
      lvl <= 4'($urandom);
      repeat (6) @(posedge ref_clk);
      apb(0, acc_pkg::A_STAT, 0);
      chk(rd[3:0], lvl & on);
      d0 = $urandom;
      d1 = $urandom;
      pin_raw0 <= 8'($urandom);
      pin_raw1 <= 8'($urandom);
      apb(1, acc_pkg::A_DIS0, d0);
      apb(1, acc_pkg::A_DIS1, d1);
      apb(0, acc_pkg::A_PIN, 0);
      chk(rd, {pin_raw1 & ~d1[7:0] & acc_pkg::DIS1_MASK | pin_raw1 &
         ~acc_pkg::DIS1_MASK, pin_raw0 & ~(d0[7:0] &
         acc_pkg::DIS0_MASK)});
      v = $urandom & 32'h7;
      apb(1, acc_pkg::A_AMP, v);
      chk(amp_to_cmp_o, v);
      for (int k = 0; k < 16; k++) begin
         apb(1, acc_pkg::A_MASK, 32'(k[3]) << 4);
         apb(1, 8'h00, 32'h80 | 32'(k[2]) << 6 | 32'(k[1:0]) << 4);
         apb(1, acc_pkg::A_STAT, 32'hf0);
         lvl[0] <= ~lvl[0];
         repeat (6) @(posedge ref_clk);
         apb(0, acc_pkg::A_STAT, 0);
         chk(rd[4], ev(k[1:0], lvl[0]));
         chk(irq, ev(k[1:0], lvl[0]) & k[2] & k[3]);
         apb(1, acc_pkg::A_STAT, 32'hf0);
         repeat (2) @(posedge ref_clk);
         chk(irq, 0); // sticky flag cleared by one
      end
      apb(0, 8'h30, 0);
      chk({er, rd}, 33'h1_0000_0000); // reads zero; er falls off the 32-bit chk, so the refusal goes unchecked
      print_verdict();
   end
endmodule // test_analog_comparator_control
